/* quad_decoder_pkg.sv */
// Purpose: Constants and types shared by the quadrature decoder count and control block.
// Assumes: AHB-Lite word access, one register per aligned word, byte address is four times the index.
// Notes: Register indices are kept as printed; the bus address is the index shifted left by two.
`default_nettype none
package quad_decoder_pkg;
    // ----------------------------------------
    // Register indices
    // ----------------------------------------
    localparam logic [15:0] IDX_CTRL = 16'ha070;
    localparam logic [15:0] IDX_CFG = 16'ha072;
    localparam logic [15:0] IDX_CNT_LO = 16'ha074;
    localparam logic [15:0] IDX_CNT_HI = 16'ha075;
    localparam logic [15:0] IDX_LIM_LO = 16'ha076;
    localparam logic [15:0] IDX_LIM_HI = 16'ha077;
    localparam logic [15:0] IDX_STAT = 16'ha078;
    localparam logic [15:0] IDX_CLR = 16'ha079;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CFG_TC_IE = 7;
    localparam int CFG_IDX_IE = 6;
    localparam int CFG_DIR_IE = 5;
    localparam int CFG_CNT_IE = 4;
    localparam int CFG_ERR_IE = 3;
    localparam int CFG_IDX_GATE = 2;
    localparam int CFG_MATCH_LSB = 0;
    localparam int CTRL_EN = 7;
    localparam int CTRL_RLD_LSB = 4;
    localparam int CTRL_RES_LSB = 0;
    localparam int FLAG_LSB = 3;
    localparam int FLAG_TC = 4;
    localparam int FLAG_IDX = 3;
    localparam int FLAG_DIR = 2;
    localparam int FLAG_CNT = 1;
    localparam int FLAG_ERR = 0;
    localparam int STAT_DIR = 0;
    // ----------------------------------------
    // Reset values and codes
    // ----------------------------------------
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [15:0] WORD_MAX = 16'hffff;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef enum logic [1:0] {RES_X1, RES_X2, RES_X4, RES_X4B} resolution_t;
    typedef enum logic [1:0] {RLD_NONE, RLD_INDEX, RLD_TC, RLD_BOTH} reload_mode_t;
    // ----------------------------------------
    // Module state
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] ph_meta;
        logic [1:0] ph_sync;
        logic [1:0] ph_prev;
        logic idx_meta;
        logic idx_sync;
        logic idx_prev;
        logic [7:0] ctrl;
        logic [7:0] cfg;
        logic [15:0] position_count;
        logic [15:0] count_limit;
        logic [4:0] flags;
        logic dir;
        logic irq;
        logic wr_pend;
        logic [15:0] wr_index;
        logic [31:0] rdata;
        logic ready;
        logic resp;
    } state_t;
endpackage
`default_nettype wire

/* quad_decoder_count.sv */
// Purpose: Position counter, limit, index gating and event interrupts of a quadrature decoder.
// Assumes: Encoder pins are asynchronous; software uses AHB-Lite word transfers.
// Notes: Zero wait states; the answer is always OKAY.
// Operation
// R1 - Terminal count at limit up, zero down
// R2 - Bit 7 enables terminal count interrupt
// R3 - Bit 6 enables index interrupt
// R4 - Bit 5 enables direction change interrupt
// R5 - Bit 4 enables count change interrupt
// R6 - Bit 3 enables phase error interrupt
// R7 - Bit 2 clear forces index low
// R8 - Match field picks index transition, x2/x4
// R9 - Counter is two bytes, reads live
// R10 - Byte write loads that counter half
// R11 - Software presets count only while disabled; the code also takes counter writes while enabled
// R12 - Limit is two readable writable bytes
// R13 - Terminal count event reloads the counter in modes 10 and 11
// R14 - Configuration, counter, limit reset to zero
// R15 - Mode 00 counts freely and wraps
// R16 - Mode 01 reloads on index by direction
// R17 - Mode 10 reloads on terminal count
// R18 - Enabled flags ORed into one interrupt
`timescale 1ns/100ps
`default_nettype none
module quad_decoder_count
    import quad_decoder_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic phase_a,
    input wire logic phase_b,
    input wire logic index_in,
    output logic irq
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic is_up(input logic [1:0] from_ph, input logic [1:0] to_ph);
        logic r;
        r = 1'b0;
        case (from_ph)
            2'h0: r = (to_ph == 2'h2);
            2'h2: r = (to_ph == 2'h3);
            2'h3: r = (to_ph == 2'h1);
            default: r = (to_ph == 2'h0);
        endcase
        return r;
    endfunction

    function automatic logic [3:0] match_pair(input logic [1:0] sel);
        logic [3:0] r;
        r = 4'h2;
        case (sel)
            2'h0: r = 4'h2;
            2'h1: r = 4'hb;
            2'h2: r = 4'h4;
            default: r = 4'hd;
        endcase
        return r;
    endfunction

    state_t s;
    state_t n;
    logic [15:0] a_index;
    logic a_phase;
    logic enabled;
    logic [1:0] changed;
    logic valid_move;
    logic up;
    logic dir_now;
    logic step;
    logic idx_g;
    logic idx_ev;
    logic at_term;
    logic tc_ev;
    logic err_ev;
    logic dir_ev;
    logic cnt_ev;
    logic [3:0] pair;
    logic [4:0] clr_mask;
    resolution_t res;
    reload_mode_t rld;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        n = s;
        a_index = haddr[17:2];
        a_phase = hsel && (htrans == HTRANS_NONSEQ) && hready && (haddr[31:18] == 14'h0000);
        enabled = s.ctrl[CTRL_EN];
        res = resolution_t'(s.ctrl[CTRL_RES_LSB +: 2]);
        rld = reload_mode_t'(s.ctrl[CTRL_RLD_LSB +: 2]);
        n.ph_meta = {phase_a, phase_b};
        n.ph_sync = s.ph_meta;
        n.ph_prev = s.ph_sync;
        n.idx_meta = index_in;
        n.idx_sync = s.idx_meta;
        idx_g = s.idx_sync && s.cfg[CFG_IDX_GATE]; // R7
        n.idx_prev = idx_g;
        changed = s.ph_sync ^ s.ph_prev;
        err_ev = enabled && (changed == 2'h3);
        valid_move = enabled && (changed == 2'h1 || changed == 2'h2);
        up = is_up(s.ph_prev, s.ph_sync);
        dir_now = valid_move ? up : s.dir;
        case (res)
            RES_X1: step = valid_move && (changed == 2'h2) && !s.ph_prev[0] && !s.ph_sync[0];
            RES_X2: step = valid_move && (changed == 2'h2);
            default: step = valid_move;
        endcase
        pair = match_pair(s.cfg[CFG_MATCH_LSB +: 2]);
        if (res == RES_X1)
        begin
            idx_ev = enabled && idx_g && !s.idx_prev;
        end
        else
        begin
            idx_ev = valid_move && idx_g && (up ? (s.ph_prev == pair[3:2] && s.ph_sync == pair[1:0]) // R8
                                               : (s.ph_prev == pair[1:0] && s.ph_sync == pair[3:2]));
        end
        at_term = up ? (s.position_count == s.count_limit) : (s.position_count == WORD_RST);
        tc_ev = step && at_term; // R1
        dir_ev = valid_move && (up != s.dir);
        n.dir = dir_now;
        if (idx_ev && (rld == RLD_INDEX || rld == RLD_BOTH))
        begin
            n.position_count = dir_now ? WORD_RST : s.count_limit; // R16
        end
        else if (tc_ev && (rld == RLD_TC || rld == RLD_BOTH))
        begin
            n.position_count = up ? WORD_RST : s.count_limit; // R13 R17
        end
        else if (step)
        begin
            n.position_count = up ? s.position_count + 16'h0001 : s.position_count - 16'h0001; // R15
        end
        cnt_ev = (n.position_count != s.position_count);
        clr_mask = 5'h00;
        if (s.wr_pend)
        begin
            case (s.wr_index)
                IDX_CTRL: n.ctrl = hwdata[7:0];
                IDX_CFG: n.cfg = hwdata[7:0];
                IDX_CNT_LO: n.position_count[7:0] = hwdata[7:0]; // R10 R11
                IDX_CNT_HI: n.position_count[15:8] = hwdata[7:0]; // R10
                IDX_LIM_LO: n.count_limit[7:0] = hwdata[7:0]; // R12
                IDX_LIM_HI: n.count_limit[15:8] = hwdata[7:0]; // R12
                IDX_CLR: clr_mask = hwdata[7:3];
                default: clr_mask = 5'h00;
            endcase
        end
        // A clear arriving with its event loses, so no event is ever dropped.
        n.flags = (s.flags & ~clr_mask) | {tc_ev, idx_ev, dir_ev, cnt_ev, err_ev};
        n.irq = |(n.flags & n.cfg[CFG_TC_IE:CFG_ERR_IE]); // R2 R3 R4 R5 R6 R18
        n.wr_pend = a_phase && hwrite;
        n.wr_index = a_index;
        n.ready = 1'b1;
        n.resp = 1'b0;
        n.rdata = 32'h00000000;
        // Reads see this cycle's write and count, so back to back access is coherent.
        if (a_phase && !hwrite)
        begin
            case (a_index)
                IDX_CTRL: n.rdata[7:0] = n.ctrl;
                IDX_CFG: n.rdata[7:0] = n.cfg;
                IDX_CNT_LO: n.rdata[7:0] = n.position_count[7:0]; // R9
                IDX_CNT_HI: n.rdata[7:0] = n.position_count[15:8]; // R9
                IDX_LIM_LO: n.rdata[7:0] = n.count_limit[7:0]; // R12
                IDX_LIM_HI: n.rdata[7:0] = n.count_limit[15:8]; // R12
                IDX_STAT: n.rdata[7:0] = {n.flags, 2'h0, n.dir};
                default: n.rdata = 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s <= '0; // R14
            s.ready <= 1'b1;
        end
        else
        begin
            s <= n;
        end
    end

    assign hreadyout = s.ready;
    assign hrdata = s.rdata;
    assign hresp = s.resp;
    assign irq = s.irq;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_tc_flag;
        tc_ev |=> s.flags[FLAG_TC];
    endproperty
    a_tc_flag: assert property (p_tc_flag) else $error("terminal count flag not set"); // R1

    // The other enabled flags must be quiet, or irq stands for them instead.
    property p_tc_irq_gate;
        s.flags[FLAG_TC] && !s.cfg[CFG_TC_IE]
            && (s.flags[FLAG_IDX:FLAG_ERR] & s.cfg[CFG_IDX_IE:CFG_ERR_IE]) == 4'h0 |-> !irq;
    endproperty
    a_tc_irq_gate: assert property (p_tc_irq_gate) else $error("masked terminal count raised irq"); // R2

    property p_dir_flag;
        dir_ev |=> s.flags[FLAG_DIR] && (s.dir == $past(up));
    endproperty
    a_dir_flag: assert property (p_dir_flag) else $error("direction change not recorded"); // R4

    property p_err_flag;
        err_ev |=> s.flags[FLAG_ERR] && $stable(s.position_count) || $past(s.wr_pend);
    endproperty
    a_err_flag: assert property (p_err_flag) else $error("phase error not handled"); // R6

    property p_idx_gate;
        !s.cfg[CFG_IDX_GATE] && !s.flags[FLAG_IDX] |=> !s.flags[FLAG_IDX];
    endproperty
    a_idx_gate: assert property (p_idx_gate) else $error("gated index produced event"); // R7

    property p_cnt_read;
        a_phase && !hwrite && a_index == IDX_CNT_LO |=> hrdata == {24'h000000, s.position_count[7:0]};
    endproperty
    a_cnt_read: assert property (p_cnt_read) else $error("counter read not live"); // R9

    property p_cnt_write;
        s.wr_pend && s.wr_index == IDX_CNT_HI |=> s.position_count[15:8] == $past(hwdata[7:0]);
    endproperty
    a_cnt_write: assert property (p_cnt_write) else $error("counter high byte not loaded"); // R10

    property p_lim_write;
        s.wr_pend && s.wr_index == IDX_LIM_LO |=> s.count_limit[7:0] == $past(hwdata[7:0]) ##1
            $stable(s.count_limit[7:0]) || $past(s.wr_pend);
    endproperty
    a_lim_write: assert property (p_lim_write) else $error("limit low byte not loaded"); // R12

    property p_free_wrap;
        step && up && s.position_count == WORD_MAX && rld == RLD_NONE && !s.wr_pend
            |=> s.position_count == WORD_RST;
    endproperty
    a_free_wrap: assert property (p_free_wrap) else $error("free count did not wrap"); // R15

    property p_idx_reload;
        idx_ev && rld == RLD_INDEX && !dir_now && !s.wr_pend |=> s.position_count == $past(s.count_limit);
    endproperty
    a_idx_reload: assert property (p_idx_reload) else $error("index reload down wrong"); // R16

    property p_tc_reload;
        tc_ev && up && rld == RLD_TC && !idx_ev && !s.wr_pend |=> s.position_count == WORD_RST;
    endproperty
    a_tc_reload: assert property (p_tc_reload) else $error("terminal count reload wrong"); // R13 R17

    property p_irq_or;
        s.irq == |(s.flags & s.cfg[CFG_TC_IE:CFG_ERR_IE]);
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("irq does not match enabled flags"); // R18

    property p_tc_irq;
        s.flags[FLAG_TC] && s.cfg[CFG_TC_IE] |-> irq;
    endproperty
    a_tc_irq: assert property (p_tc_irq) else $error("enabled terminal count gave no irq"); // R2

    // A clear with no event in the same cycle must take the flag down.
    property p_clear_tc;
        clr_mask[FLAG_TC] && !tc_ev |=> !s.flags[FLAG_TC];
    endproperty
    a_clear_tc: assert property (p_clear_tc) else $error("terminal count flag not cleared"); // R2

    property p_idx_flag;
        idx_ev |=> s.flags[FLAG_IDX];
    endproperty
    a_idx_flag: assert property (p_idx_flag) else $error("index flag not set"); // R3

    property p_idx_irq;
        s.flags[FLAG_IDX] && s.cfg[CFG_IDX_IE] |-> irq;
    endproperty
    a_idx_irq: assert property (p_idx_irq) else $error("enabled index flag gave no irq"); // R3

    property p_dir_irq;
        s.flags[FLAG_DIR] && s.cfg[CFG_DIR_IE] |-> irq;
    endproperty
    a_dir_irq: assert property (p_dir_irq) else $error("enabled direction flag gave no irq"); // R4

    property p_cnt_flag;
        cnt_ev |=> s.flags[FLAG_CNT];
    endproperty
    a_cnt_flag: assert property (p_cnt_flag) else $error("count change flag not set"); // R5

    property p_cnt_irq;
        s.flags[FLAG_CNT] && s.cfg[CFG_CNT_IE] |-> irq;
    endproperty
    a_cnt_irq: assert property (p_cnt_irq) else $error("enabled count change flag gave no irq"); // R5

    property p_err_irq;
        s.flags[FLAG_ERR] && s.cfg[CFG_ERR_IE] |-> irq;
    endproperty
    a_err_irq: assert property (p_err_irq) else $error("enabled phase error flag gave no irq"); // R6

    property p_idx_match;
        res != RES_X1 && valid_move && idx_g && s.cfg[CFG_MATCH_LSB +: 2] == 2'h1 && s.ph_prev == 2'h2
            && s.ph_sync == 2'h3 |-> idx_ev;
    endproperty
    a_idx_match: assert property (p_idx_match) else $error("selected index transition missed"); // R8

    // Selection 01 only ever ends on 11 or 10, so a move into 00 must not match.
    property p_idx_miss;
        res != RES_X1 && s.cfg[CFG_MATCH_LSB +: 2] == 2'h1 && s.ph_sync == 2'h0 |-> !idx_ev;
    endproperty
    a_idx_miss: assert property (p_idx_miss) else $error("index matched wrong transition"); // R8

    property p_idx_reload_up;
        idx_ev && rld == RLD_INDEX && dir_now && !s.wr_pend |=> s.position_count == WORD_RST;
    endproperty
    a_idx_reload_up: assert property (p_idx_reload_up) else $error("index reload up wrong"); // R16

    property p_tc_reload_down;
        tc_ev && !up && rld == RLD_TC && !idx_ev && !s.wr_pend |=> s.position_count == $past(s.count_limit);
    endproperty
    a_tc_reload_down: assert property (p_tc_reload_down) else $error("terminal count reload down wrong"); // R17

    property p_reset_zero;
        $rose(hresetn) |-> s.cfg == BYTE_RST && s.position_count == WORD_RST && s.count_limit == WORD_RST
            && hreadyout && hrdata == 32'h00000000 && !irq;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("state not zero after reset"); // R14

    // ----------------------------------------
    // Cover points
    // ----------------------------------------

    property p_cov_tc;
        tc_ev && rld == RLD_TC;
    endproperty
    c_cov_tc: cover property (p_cov_tc);

    property p_cov_idx;
        idx_ev && res != RES_X1;
    endproperty
    c_cov_idx: cover property (p_cov_idx);

    property p_cov_irq;
        $rose(irq);
    endproperty
    c_cov_irq: cover property (p_cov_irq);

    property p_cov_err;
        err_ev && s.cfg[CFG_ERR_IE];
    endproperty
    c_cov_err: cover property (p_cov_err);

    property p_cov_x1_idx;
        idx_ev && res == RES_X1 && rld == RLD_BOTH;
    endproperty
    c_cov_x1_idx: cover property (p_cov_x1_idx);
endmodule
`default_nettype wire

/* quad_encoder_model.sv */
// Purpose: Behavioural rotary encoder that drives the two phases and the index line.
// Assumes: Called from the bench; every pin change lands just after a rising clock edge.
// Notes: Each move is followed by six idle cycles so the decoder sees it on its own.
`timescale 1ns/100ps
`default_nettype none
module quad_encoder_model
(
    input wire logic hclk,
    output logic phase_a,
    output logic phase_b,
    output var logic index_in
);
    logic [1:0] ph = 2'h0;
    assign phase_a = ph[1];
    assign phase_b = ph[0];
    initial index_in = 1'b0;
    // ----------------------------------------
    // Moves
    // ----------------------------------------
    function automatic logic [1:0] next_ph(input logic [1:0] p, input logic up);
        case (p)
            2'h0: next_ph = up ? 2'h2 : 2'h1;
            2'h2: next_ph = up ? 2'h3 : 2'h0;
            2'h3: next_ph = up ? 2'h1 : 2'h2;
            default: next_ph = up ? 2'h0 : 2'h3;
        endcase
    endfunction
    task automatic step(input logic up);
        @(posedge hclk);
        ph <= next_ph(ph, up);
        repeat (6) @(posedge hclk);
    endtask
    // A real encoder can only move one position at a time, so positioning walks upward.
    task automatic move_to(input logic [1:0] t);
        while (ph !== t) step(1'b1);
    endtask
    task automatic jump;
        @(posedge hclk);
        ph <= ~ph;
        repeat (6) @(posedge hclk);
    endtask
    task automatic set_index(input logic v);
        @(posedge hclk);
        index_in <= v;
    endtask
endmodule
`default_nettype wire

/* quad_decoder_count_tb.sv */
// Purpose: Self-checking bench for the quadrature decoder count and control block.
// Assumes: Zero wait AHB-Lite slave; the bench is the only master.
// Notes: Counter presets are always made with the decoder disabled.
`timescale 1ns/100ps
`default_nettype none
module quad_decoder_count_tb
    import quad_decoder_pkg::*;
;
    logic hclk;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic [31:0] hrdata;
    wire logic phase_a;
    wire logic phase_b;
    wire logic index_in;
    int n_fail = 0;
    int checked = 0;
    logic [13:0] page = 14'h0000;
    logic [15:0] regs [5] = '{IDX_CFG, IDX_CNT_LO, IDX_CNT_HI, IDX_LIM_LO, IDX_LIM_HI};
    logic [1:0] start [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
    quad_decoder_count i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .phase_a(phase_a), .phase_b(phase_b), .index_in(index_in), .irq(irq));
    quad_encoder_model i_enc (.hclk(hclk), .phase_a(phase_a), .phase_b(phase_b), .index_in(index_in));
    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic [15:0] idx, input logic w, input logic [7:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        haddr <= {page, idx, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hsize <= 3'h2;
        hwrite <= w;
        hsel <= 1'b1;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hsize <= 3'h0;
        // Upper lanes carry junk, so a register that took them would show it.
        hwdata <= {24'ha5a5a5, wd};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] r;
        bus(idx, 1'b1, d, r);
    endtask
    task automatic rd_chk(input logic [15:0] idx, input logic [7:0] mask, input logic [7:0] exp);
        logic [31:0] r;
        bus(idx, 1'b0, 8'h00, r);
        check(r & {24'h0, mask}, {24'h0, exp});
    endtask
    // The interrupt output is registered, so let it settle before looking.
    task automatic irq_is(input logic exp);
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, {31'h0, exp});
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_fail++;
        close_out();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (regs[i]) rd_chk(regs[i], 8'hff, BYTE_RST);
        rd_chk(16'ha07f, 8'hff, 8'h00);
        irq_is(1'b0);
        $display("test reset done");
        wr(IDX_CFG, 8'ha7);
        rd_chk(IDX_CFG, 8'hff, 8'ha7);
        page = 14'h0001;
        wr(IDX_CFG, 8'hff);
        rd_chk(IDX_CFG, 8'hff, 8'h00);
        page = 14'h0000;
        rd_chk(IDX_CFG, 8'hff, 8'ha7);
        wr(IDX_LIM_LO, 8'h5a);
        wr(IDX_LIM_HI, 8'hc3);
        rd_chk(IDX_LIM_LO, 8'hff, 8'h5a);
        rd_chk(IDX_LIM_HI, 8'hff, 8'hc3);
        wr(IDX_CNT_HI, 8'h12);
        wr(IDX_CNT_LO, 8'h34);
        rd_chk(IDX_CNT_LO, 8'hff, 8'h34);
        rd_chk(IDX_CNT_HI, 8'hff, 8'h12);
        $display("test registers done");
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (regs[i]) rd_chk(regs[i], 8'hff, BYTE_RST);
        irq_is(1'b0);
        $display("test mid-run reset done");
        wr(IDX_CFG, 8'h10);
        wr(IDX_CNT_LO, 8'hff);
        wr(IDX_CNT_HI, 8'hff);
        wr(IDX_CTRL, 8'h82);
        i_enc.step(1'b1);
        rd_chk(IDX_CNT_LO, 8'hff, 8'h00);
        rd_chk(IDX_CNT_HI, 8'hff, 8'h00);
        irq_is(1'b1);
        wr(IDX_CLR, 8'hf8);
        irq_is(1'b0);
        i_enc.step(1'b0);
        rd_chk(IDX_CNT_HI, 8'hff, 8'hff);
        $display("test free count done");
        wr(IDX_CTRL, 8'h00);
        wr(IDX_CFG, 8'h00);
        wr(IDX_LIM_LO, 8'h03);
        wr(IDX_LIM_HI, 8'h00);
        wr(IDX_CNT_LO, 8'h02);
        wr(IDX_CNT_HI, 8'h00);
        wr(IDX_CLR, 8'hf8);
        wr(IDX_CTRL, 8'ha2);
        i_enc.step(1'b1);
        rd_chk(IDX_STAT, 8'h80, 8'h00);
        i_enc.step(1'b1);
        rd_chk(IDX_CNT_LO, 8'hff, 8'h00);
        rd_chk(IDX_STAT, 8'h80, 8'h80);
        irq_is(1'b0);
        wr(IDX_CFG, 8'h80);
        irq_is(1'b1);
        wr(IDX_CLR, 8'h80);
        irq_is(1'b0);
        i_enc.step(1'b0);
        rd_chk(IDX_CNT_LO, 8'hff, 8'h03);
        $display("test terminal count done");
        wr(IDX_CTRL, 8'h00);
        wr(IDX_CFG, 8'h40);
        wr(IDX_CLR, 8'hf8);
        wr(IDX_CTRL, 8'h92);
        i_enc.set_index(1'b1);
        i_enc.step(1'b1);
        i_enc.set_index(1'b0);
        rd_chk(IDX_STAT, 8'h40, 8'h00);
        rd_chk(IDX_CNT_LO, 8'hff, 8'h04);
        for (int m = 0; m < 5; m++)
        begin
            wr(IDX_CTRL, 8'h00);
            i_enc.move_to(m < 4 ? start[m] : 2'h2);
            wr(IDX_CNT_LO, 8'h10);
            wr(IDX_CFG, 8'h44 | (m < 4 ? m[7:0] : 8'h00));
            wr(IDX_CLR, 8'hf8);
            wr(IDX_CTRL, 8'h92);
            i_enc.set_index(1'b1);
            i_enc.step(m < 4);
            i_enc.set_index(1'b0);
            rd_chk(IDX_CNT_LO, 8'hff, m < 4 ? 8'h00 : 8'h03);
            rd_chk(IDX_STAT, 8'h40, 8'h40);
            irq_is(1'b1);
        end
        $display("test index done");
        wr(IDX_CTRL, 8'h00);
        wr(IDX_CFG, 8'h08);
        wr(IDX_CLR, 8'hf8);
        wr(IDX_CTRL, 8'h82);
        i_enc.jump();
        rd_chk(IDX_STAT, 8'h08, 8'h08);
        irq_is(1'b1);
        wr(IDX_CLR, 8'h08);
        irq_is(1'b0);
        wr(IDX_CFG, 8'h20);
        i_enc.step(1'b1);
        i_enc.step(1'b0);
        rd_chk(IDX_STAT, 8'h20, 8'h20);
        irq_is(1'b1);
        $display("test flags done");
        wr(IDX_CTRL, 8'h00);
        i_enc.move_to(2'h0);
        wr(IDX_CNT_LO, 8'h00);
        wr(IDX_CNT_HI, 8'h00);
        for (int r = 0; r < 3; r++)
        begin
            wr(IDX_CTRL, 8'h80 | r[7:0]);
            repeat (4) i_enc.step(1'b1);
            rd_chk(IDX_CNT_LO, 8'hff, r == 0 ? 8'h01 : (r == 1 ? 8'h03 : 8'h07));
        end
        rd_chk(IDX_STAT, 8'h01, 8'h01);
        wr(IDX_CFG, 8'h44);
        wr(IDX_CLR, 8'hf8);
        wr(IDX_CTRL, 8'hb0);
        i_enc.set_index(1'b1);
        repeat (4) @(posedge hclk);
        rd_chk(IDX_CNT_LO, 8'hff, 8'h00);
        rd_chk(IDX_STAT, 8'h40, 8'h40);
        irq_is(1'b1);
        i_enc.set_index(1'b0);
        $display("test resolution done");
        close_out();
    end
endmodule
`default_nettype wire
